/* File: src/i2cs_params.svh */
// Constants for the two-wire slave receive port.
`ifndef I2CS_PARAMS_SVH
`define I2CS_PARAMS_SVH

// ----------------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------------
`define I2CS_BYTE_BITS 4'h8
`define I2CS_ACK_BIT 4'h9
`define I2CS_RW_POS 0

// ----------------------------------------------------------------------
// Ten-bit address marker in the high address byte
// ----------------------------------------------------------------------
`define I2CS_TEN_MARK 5'h1e
`define I2CS_TEN_MARK_HI 7
`define I2CS_TEN_MARK_LO 3

// ----------------------------------------------------------------------
// Receive FIFO shape and reset values
// ----------------------------------------------------------------------
`define I2CS_FIFO_WIDTH 8
`define I2CS_FIFO_DEPTH 32
`define I2CS_ADDR_RESET 8'h00
`define I2CS_BYTE_RESET 8'h00

`endif

/* File: src/i2cs_pkg.sv */
// Types shared by the two-wire slave receive port.
package i2cs_pkg;

   // -------------------------------------------------------------------
   // Protocol states
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      I2CS_IDLE,
      I2CS_ADDR,
      I2CS_ADDR_LO,
      I2CS_RX,
      I2CS_TX
   } i2cs_state_t;

   // -------------------------------------------------------------------
   // Status flags seen by software
   // -------------------------------------------------------------------
   typedef struct packed {
      logic buffer_full_flag;
      logic receive_overflow_flag;
      logic port_interrupt_flag;
      logic update_address_flag;
   } i2cs_status_t;

   // -------------------------------------------------------------------
   // Bus levels and bit events handed to the core clock domain
   // -------------------------------------------------------------------
   typedef struct packed {
      logic scl;
      logic sda;
      logic bit_stb;
      logic bit_val;
   } i2cs_link_t;

endpackage : i2cs_pkg

/* File: src/i2cs_fifo.sv */
// Receive FIFO with a registered output stage.
`timescale 1ns/1ps
module i2cs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;

   // -------------------------------------------------------------------
   // Handshakes
   // -------------------------------------------------------------------
   wire push = ce & in_valid & in_ready;
   wire stage_free = ~out_valid | out_ready;
   wire pop = ce & stage_free & (count != '0);
   wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
      end
      else if (ce)
      begin
         if (push)
            wptr <= wptr + 1'b1;
         if (pop)
            rptr <= rptr + 1'b1;
         count <= next_count;
         in_ready <= (next_count != DEPTH[AW:0]);
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wptr] <= in_data;
   end

   // The output stage keeps the top-level data port straight from a flop.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         out_valid <= 1'b0;
         out_data <= '0;
      end
      else if (ce && stage_free)
      begin
         out_valid <= (count != '0);
         if (count != '0)
            out_data <= mem[rptr];
      end
   end

endmodule : i2cs_fifo

/* File: src/i2cs_link.sv */
// Bus-clock sampler and crossing into the core clock domain.
`timescale 1ns/1ps
module i2cs_link (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_clk,
   input wire logic sda_in,
   output i2cs_pkg::i2cs_link_t link
);
   logic cap;
   logic tgl;
   logic tgl_m;
   logic tgl_s;
   logic tgl_d;
   logic scl_m;
   logic sda_m;

   // -------------------------------------------------------------------
   // Bus clock domain
   // -------------------------------------------------------------------
   // RQ7 rising edge sample
   always_ff @(posedge scl_clk or posedge rst)
   begin
      if (rst)
      begin
         cap <= 1'b0;
         tgl <= 1'b0;
      end
      else
      begin
         cap <= sda_in;
         tgl <= ~tgl;
      end
   end

   // -------------------------------------------------------------------
   // Core clock domain
   // -------------------------------------------------------------------
   // The captured bit is stable for a whole high phase of the bus clock,
   // long after the toggle has passed its two flops, so it is read here.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tgl_m <= 1'b0;
         tgl_s <= 1'b0;
         tgl_d <= 1'b0;
         scl_m <= 1'b1;
         sda_m <= 1'b1;
         link <= '{scl: 1'b1, sda: 1'b1, bit_stb: 1'b0, bit_val: 1'b0};
      end
      else if (ce)
      begin
         tgl_m <= tgl;
         tgl_s <= tgl_m;
         tgl_d <= tgl_s;
         scl_m <= scl_clk;
         sda_m <= sda_in;
         link.scl <= scl_m;
         link.sda <= sda_m;
         link.bit_stb <= tgl_s ^ tgl_d;
         if (tgl_s ^ tgl_d)
            link.bit_val <= cap;
      end
   end

endmodule : i2cs_link

/* File: src/i2cs_top.sv */
// Two-wire slave receive port with address match and receive FIFO.
`timescale 1ns/1ps
`include "i2cs_params.svh"

// Behaviour
// RQ1 - Pins are inputs; port overrides them only to drive outgoing bits.
// RQ2 - Matched address or data byte: acknowledge by itself and load buffer.
// RQ3 - No acknowledge when buffer-full or overflow already set.
// RQ4 - Refused byte is not loaded, yet the interrupt flag is still set; the code sets no flag for a refused address byte.
// RQ5 - Buffer read clears buffer-full; only software clears overflow.
// RQ6 - Once enabled, wait for START, then shift in eight bits.
// RQ7 - Every incoming bit is sampled on the rising bus clock edge.
// RQ8 - Compare shift bits seven to one at the eighth falling clock edge.
// RQ9 - On clean match: load, buffer-full, acknowledge, flag at ninth fall.
// RQ10 - Ten-bit form takes two address bytes, first marked 11110.
// RQ11 - Master sends the first ten-bit byte as a write.
// RQ12 - High ten-bit byte sets interrupt, buffer-full and update flags.
// RQ13 - Address write clears update flag and releases the clock line.
// RQ14 - Low byte sets all three flags; next address write releases again.
// RQ15 - Software reads buffer and clears interrupt flag after each byte.
// RQ16 - Repeated START high byte for reads sets interrupt and buffer-full.
// RQ17 - Hold clock line low while the update-address flag is set.
// RQ18 - Acknowledge drives data low; interrupt is flag AND its enable.
module i2cs_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic scl_drive_n,
   output logic sda_drive_n,
   input wire logic port_enable,
   input wire logic ten_bit_mode,
   input wire logic int_enable,
   input wire logic addr_wr,
   input wire logic [7:0] addr_wdata,
   input wire logic [7:0] tx_byte,
   input wire logic ovf_clear,
   input wire logic int_flag_clear,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output i2cs_pkg::i2cs_status_t status,
   output logic irq
);
   i2cs_pkg::i2cs_link_t lk;
   i2cs_pkg::i2cs_state_t state;
   i2cs_pkg::i2cs_state_t next_state;
   logic [7:0] slave_address_register;
   logic [7:0] rx_shift_register;
   logic [7:0] rx_buffer;
   logic [7:0] tx_shift;
   logic [3:0] cnt;
   logic scl_d;
   logic sda_d;
   logic take;
   logic read_dir;
   logic ten_matched;
   logic last_bit;
   logic fifo_ready;

   // -------------------------------------------------------------------
   // Link sampler and receive FIFO
   // -------------------------------------------------------------------
   i2cs_link u_link (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .scl_clk(scl_clk),
      .sda_in(sda_in),
      .link(lk)
   );

   // RQ5 move clears buffer-full
   wire buf_move = status.buffer_full_flag & fifo_ready;

   i2cs_fifo #(
      .WIDTH(`I2CS_FIFO_WIDTH),
      .DEPTH(`I2CS_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_valid(status.buffer_full_flag),
      .in_ready(fifo_ready),
      .in_data(rx_buffer),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // -------------------------------------------------------------------
   // Address comparison
   // -------------------------------------------------------------------
   // RQ8 bits seven to one
   function automatic logic hit7(input logic [7:0] sh, input logic [7:0] ad);
      hit7 = (sh[7:1] == ad[7:1]);
   endfunction : hit7

   // RQ10 ten-bit marker
   function automatic logic is_ten_hi(input logic [7:0] sh);
      is_ten_hi = (sh[`I2CS_TEN_MARK_HI:`I2CS_TEN_MARK_LO] == `I2CS_TEN_MARK);
   endfunction : is_ten_hi

   // -------------------------------------------------------------------
   // Bus events
   // -------------------------------------------------------------------
   wire scl_fall = scl_d & ~lk.scl;
   wire bus_start = lk.scl & scl_d & sda_d & ~lk.sda;
   wire bus_stop = lk.scl & scl_d & ~sda_d & lk.sda;
   wire fall8 = scl_fall & (cnt == `I2CS_BYTE_BITS);
   wire fall9 = scl_fall & (cnt == `I2CS_ACK_BIT);
   wire active = (state != i2cs_pkg::I2CS_IDLE);
   wire rx_state = active & (state != i2cs_pkg::I2CS_TX);
   wire flags_clear = ~status.buffer_full_flag &
      ~status.receive_overflow_flag;
   wire rw_bit = rx_shift_register[`I2CS_RW_POS];

   // RQ16 read needs earlier match
   wire hi_ok = ten_bit_mode ?
      (is_ten_hi(rx_shift_register) &
       hit7(rx_shift_register, slave_address_register) &
       (~rw_bit | ten_matched)) :
      hit7(rx_shift_register, slave_address_register);
   wire lo_ok = (rx_shift_register == slave_address_register);

   // RQ3 refuse when flags set
   wire accept =
      (state == i2cs_pkg::I2CS_ADDR) ? (hi_ok & flags_clear) :
      (state == i2cs_pkg::I2CS_ADDR_LO) ? (lo_ok & flags_clear) :
      (state == i2cs_pkg::I2CS_RX) ? flags_clear : 1'b0;

   // RQ2 load on accepted byte
   wire do_load = fall9 & rx_state & take;
   // RQ4 flag even when refused
   wire set_if = fall9 & ((rx_state & take) |
      (state == i2cs_pkg::I2CS_RX) |
      ((state == i2cs_pkg::I2CS_TX) & ~last_bit));
   // RQ12 update flag on address bytes
   wire set_ua = do_load & ten_bit_mode &
      (((state == i2cs_pkg::I2CS_ADDR) & ~read_dir) |
       (state == i2cs_pkg::I2CS_ADDR_LO));
   wire set_ovf = fall9 & (state == i2cs_pkg::I2CS_RX) &
      status.buffer_full_flag;

   // -------------------------------------------------------------------
   // Next protocol state
   // -------------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         i2cs_pkg::I2CS_IDLE:
            next_state = i2cs_pkg::I2CS_IDLE;
         i2cs_pkg::I2CS_ADDR:
         begin
            if (!take)
               next_state = i2cs_pkg::I2CS_IDLE;
            else if (read_dir)
               next_state = i2cs_pkg::I2CS_TX;
            else if (ten_bit_mode && !ten_matched)
               next_state = i2cs_pkg::I2CS_ADDR_LO;
            else
               next_state = i2cs_pkg::I2CS_RX;
         end
         i2cs_pkg::I2CS_ADDR_LO:
            next_state = take ? i2cs_pkg::I2CS_RX : i2cs_pkg::I2CS_IDLE;
         i2cs_pkg::I2CS_RX:
            next_state = i2cs_pkg::I2CS_RX;
         i2cs_pkg::I2CS_TX:
            next_state = last_bit ? i2cs_pkg::I2CS_IDLE : i2cs_pkg::I2CS_TX;
         default:
            next_state = i2cs_pkg::I2CS_IDLE;
      endcase
   end

   // -------------------------------------------------------------------
   // Sequencing
   // -------------------------------------------------------------------
   // RQ6 idle until START
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state <= i2cs_pkg::I2CS_IDLE;
      else if (ce)
      begin
         if (!port_enable || bus_stop)
            state <= i2cs_pkg::I2CS_IDLE;
         else if (bus_start)
            state <= i2cs_pkg::I2CS_ADDR;
         else if (fall9)
            state <= next_state;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         cnt <= 4'h0;
         last_bit <= 1'b1;
      end
      else if (ce)
      begin
         scl_d <= lk.scl;
         sda_d <= lk.sda;
         if (bus_start || fall9)
            cnt <= 4'h0;
         else if (lk.bit_stb && active)
            cnt <= cnt + 4'h1;
         if (lk.bit_stb)
            last_bit <= lk.bit_val;
      end
   end

   // RQ7 shift in sampled bits
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rx_shift_register <= `I2CS_BYTE_RESET;
      else if (ce && lk.bit_stb && rx_state && cnt < `I2CS_BYTE_BITS)
         rx_shift_register <= {rx_shift_register[6:0], lk.bit_val};
   end

   // RQ8 decide at eighth fall
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         take <= 1'b0;
         read_dir <= 1'b0;
      end
      else if (ce && fall8 && rx_state)
      begin
         take <= accept;
         read_dir <= rw_bit;
      end
   end

   // The ten-bit match survives a repeated START so that the read form
   // of the high byte is only honoured after a full write addressing.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ten_matched <= 1'b0;
      else if (ce)
      begin
         if (!port_enable || bus_stop)
            ten_matched <= 1'b0;
         else if (do_load && state == i2cs_pkg::I2CS_ADDR_LO)
            ten_matched <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Data line drive
   // -------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sda_drive_n <= 1'b1;
         tx_shift <= `I2CS_BYTE_RESET;
      end
      else if (ce)
      begin
         if (!port_enable || bus_start || bus_stop)
            sda_drive_n <= 1'b1;
         // RQ18 acknowledge drives low
         else if (fall8 && rx_state)
            sda_drive_n <= ~accept;
         // RQ1 drive outgoing bits
         else if (fall9 && next_state == i2cs_pkg::I2CS_TX)
         begin
            sda_drive_n <= tx_byte[7];
            tx_shift <= {tx_byte[6:0], 1'b0};
         end
         else if (fall9 || (fall8 && state == i2cs_pkg::I2CS_TX))
            sda_drive_n <= 1'b1;
         else if (scl_fall && state == i2cs_pkg::I2CS_TX)
         begin
            sda_drive_n <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
         end
      end
   end

   // -------------------------------------------------------------------
   // Buffer, flags and address register
   // -------------------------------------------------------------------
   // RQ9 load buffer at ninth fall
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rx_buffer <= `I2CS_BYTE_RESET;
      else if (ce && do_load)
         rx_buffer <= rx_shift_register;
   end

   // A freshly set flag always wins over a clear in the same cycle.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         status <= '0;
      else if (ce)
      begin
         // RQ5 buffer-full set and clear
         if (do_load)
            status.buffer_full_flag <= 1'b1;
         else if (buf_move)
            status.buffer_full_flag <= 1'b0;
         // RQ5 overflow software clear
         if (set_ovf)
            status.receive_overflow_flag <= 1'b1;
         else if (ovf_clear)
            status.receive_overflow_flag <= 1'b0;
         // RQ15 flag cleared by software
         if (set_if)
            status.port_interrupt_flag <= 1'b1;
         else if (int_flag_clear)
            status.port_interrupt_flag <= 1'b0;
         // RQ13 address write clears update flag
         if (set_ua)
            status.update_address_flag <= 1'b1;
         else if (addr_wr)
            status.update_address_flag <= 1'b0;
      end
   end

   // RQ14 software rewrites address
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         slave_address_register <= `I2CS_ADDR_RESET;
      else if (ce && addr_wr)
         slave_address_register <= addr_wdata;
   end

   // -------------------------------------------------------------------
   // Clock stretch and interrupt request
   // -------------------------------------------------------------------
   // The stretch starts at the ninth falling edge, so the line is already
   // low and holding it adds no glitch on the bus clock.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scl_drive_n <= 1'b1;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         // RQ17 hold clock while updating
         scl_drive_n <= ~((status.update_address_flag & ~addr_wr) | set_ua);
         // RQ18 flag AND enable
         irq <= status.port_interrupt_flag & int_enable;
      end
   end

endmodule : i2cs_top

/* File: tb/i2cs_master.sv */
// Behavioural two-wire bus master driving the slave port.
`timescale 1ns/1ps
module i2cs_master #(
   parameter int HALF = 320
) (
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_m,
   output logic sda_m,
   output logic stuck
);
   localparam int QTR = HALF / 2;

   initial
   begin
      scl_m = 1'b1;
      sda_m = 1'b1;
      stuck = 1'b0;
   end

   // honours the stretch
   // A held clock is waited on, but never forever.
   task raise_scl;
      scl_m = 1'b1;
      for (int i = 0; i < 4000 && scl_line !== 1'b1; i++)
         #10;
      if (scl_line !== 1'b1)
         stuck = 1'b1;
   endtask : raise_scl

   task start_cond;
      #QTR sda_m = 1'b1;
      #QTR raise_scl();
      #HALF sda_m = 1'b0;
      #HALF scl_m = 1'b0;
   endtask : start_cond

   task stop_cond;
      #QTR sda_m = 1'b0;
      #QTR raise_scl();
      #HALF sda_m = 1'b1;
      #HALF;
   endtask : stop_cond

   // data settles in the low phase
   task bit_io(input logic b, output logic r);
      #QTR sda_m = b;
      #QTR raise_scl();
      #HALF r = sda_line;
      scl_m = 1'b0;
   endtask : bit_io

   task send_byte(input logic [7:0] d, output logic ack_n);
      logic r;
      for (int k = 7; k >= 0; k--)
         bit_io(d[k], r);
      bit_io(1'b1, ack_n);
   endtask : send_byte

   task recv_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int k = 7; k >= 0; k--)
         bit_io(1'b1, d[k]);
      bit_io(nack, r);
   endtask : recv_byte
endmodule : i2cs_master

/* File: tb/i2cs_assertions.sv */
// Concurrent checks on the slave port's top-level ports.
`timescale 1ns/1ps
module i2cs_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_drive_n,
   input wire logic sda_drive_n,
   input wire logic int_enable,
   input wire logic addr_wr,
   input wire logic ovf_clear,
   input wire logic int_flag_clear,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire i2cs_pkg::i2cs_status_t status,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence ua_up;
      $rose(status.update_address_flag);
   endsequence
   sequence ua_down;
      $fell(status.update_address_flag);
   endsequence
   sequence byte_taken;
      $rose(status.buffer_full_flag);
   endsequence

   irq_gate_on_a: assert property (
      status.port_interrupt_flag && int_enable |=> irq)
      else $error("irq missing");
   irq_gate_off_a: assert property (
      !int_enable |=> !irq) else $error("irq while masked");
   stretch_hold_a: assert property (
      ua_up |-> ##[0:2] !scl_drive_n) else $error("clock not held");
   stretch_free_a: assert property (
      ua_down |-> ##[0:2] scl_drive_n) else $error("clock not freed");
   ua_clear_a: assert property (
      addr_wr |=> !status.update_address_flag)
      else $error("update flag stuck");
   ovf_clear_a: assert property (
      ovf_clear |=> !status.receive_overflow_flag)
      else $error("overflow not cleared");
   ovf_sticky_a: assert property (
      status.receive_overflow_flag && !ovf_clear
      |=> status.receive_overflow_flag) else $error("overflow lost");
   if_clear_a: assert property (
      int_flag_clear |=> !status.port_interrupt_flag)
      else $error("flag not cleared");
   if_sticky_a: assert property (
      status.port_interrupt_flag && !int_flag_clear
      |=> status.port_interrupt_flag) else $error("flag lost");
   ack_refused_a: assert property (
      $fell(sda_drive_n) |-> !$past(status.receive_overflow_flag))
      else $error("ack despite overflow");
   bf_with_if_a: assert property (
      byte_taken |-> ##[0:1] status.port_interrupt_flag)
      else $error("buffer full without flag");
   rx_hold_a: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("receive head dropped");
endmodule : i2cs_chk

bind i2cs_top i2cs_chk u_chk (.clk(clk), .rst(rst),
   .scl_drive_n(scl_drive_n), .sda_drive_n(sda_drive_n),
   .int_enable(int_enable), .addr_wr(addr_wr), .ovf_clear(ovf_clear),
   .int_flag_clear(int_flag_clear), .rx_data(rx_data),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .status(status), .irq(irq));

/* File: tb/testbench.sv */
// Self-checking bench for the two-wire slave receive port.
`timescale 1ns/1ps
module testbench;
   logic clk, rst, scl_m, sda_m, stuck, ack_n;
   logic scl_drive_n, sda_drive_n, port_enable, ten_bit_mode, int_enable;
   logic addr_wr, ovf_clear, int_flag_clear, rx_valid, rx_ready, irq;
   logic [7:0] addr_wdata, tx_byte, rx_data, got, hi, b;
   logic [9:0] a10;
   logic [6:0] a7;
   i2cs_pkg::i2cs_status_t status;
   logic [7:0] exp_q[$];
   int err_total, num_checks, acc;
   // Open-drain lines with pull-ups: any party pulling low wins.
   wire scl_line = scl_m & scl_drive_n;
   wire sda_line = sda_m & sda_drive_n;

   i2cs_top DUT (.clk(clk), .rst(rst), .ce(1'b1), .scl_clk(scl_line),
      .sda_in(sda_line), .scl_drive_n(scl_drive_n),
      .sda_drive_n(sda_drive_n), .port_enable(port_enable),
      .ten_bit_mode(ten_bit_mode), .int_enable(int_enable),
      .addr_wr(addr_wr), .addr_wdata(addr_wdata), .tx_byte(tx_byte),
      .ovf_clear(ovf_clear), .int_flag_clear(int_flag_clear),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .status(status), .irq(irq));
   i2cs_master #(.HALF(320)) master (.scl_line(scl_line),
      .sda_line(sda_line), .scl_m(scl_m), .sda_m(sda_m), .stuck(stuck));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task conclude;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // Status order is buffer full, overflow, interrupt, update address.
   task chk_st(input logic [3:0] e, input logic hold);
      check("status", {28'h0, status}, {28'h0, e});
      check("scl_drive_n", {31'h0, scl_drive_n}, {31'h0, ~hold});
   endtask : chk_st

   // Software pulse: 0 address write, 1 overflow clear, 2 flag clear.
   task pulse(input int which, input logic [7:0] d);
      @(posedge clk);
      addr_wdata <= d;
      addr_wr <= (which == 0);
      ovf_clear <= (which == 1);
      int_flag_clear <= (which == 2);
      @(posedge clk);
      addr_wr <= 1'b0;
      ovf_clear <= 1'b0;
      int_flag_clear <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse

   task xfer(input logic [7:0] d, input logic ack);
      master.send_byte(d, ack_n);
      check("ack", {31'h0, ~ack_n}, {31'h0, ack});
      if (ack)
         exp_q.push_back(d);
      repeat (10) @(posedge clk);
   endtask : xfer

   always @(posedge clk)
   begin
      if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("rx_extra", 32'h1, 32'h0);
         else
            check("rx_data", {24'h0, rx_data}, {24'h0, exp_q.pop_front()});
      end
   end

   initial
   begin
      #2000000;
      err_total++;
      conclude();
   end

   initial
   begin
      rst = 1'b1;
      {port_enable, ten_bit_mode, int_enable, addr_wr} = 4'h0;
      {ovf_clear, int_flag_clear, addr_wdata, tx_byte} = 18'h0;
      rx_ready = 1'b1;
      err_total = 0;
      num_checks = 0;
      void'($urandom(68));
      repeat (20) @(posedge clk);
      check("idle", {29'h0, sda_drive_n, rx_valid, irq}, 32'h4);
      chk_st(4'h0, 1'b0);
      rst <= 1'b0;
      port_enable <= 1'b1;
      int_enable <= 1'b1;
      repeat (5) @(posedge clk);
      a7 = 7'($urandom);
      pulse(0, {a7, 1'b0});
      master.start_cond();
      xfer({a7, 1'b0}, 1'b1);
      for (int i = 0; i < 3; i++)
         xfer(8'($urandom), 1'b1);
      chk_st(4'b0010, 1'b0);
      check("irq", {31'h0, irq}, 32'h1);
      master.stop_cond();
      pulse(2, 8'h00);
      int_enable <= 1'b0;
      chk_st(4'h0, 1'b0);
      master.start_cond();
      xfer({a7 ^ 7'h01, 1'b0}, 1'b0);
      master.stop_cond();
      chk_st(4'h0, 1'b0);
      @(posedge clk);
      rx_ready <= 1'b0;
      master.start_cond();
      xfer({a7, 1'b0}, 1'b1);
      acc = 1;
      ack_n = 1'b0;
      while (acc < 40 && ack_n == 1'b0)
      begin
         b = 8'($urandom);
         master.send_byte(b, ack_n);
         if (ack_n == 1'b0)
         begin
            exp_q.push_back(b);
            acc++;
         end
      end
      // Output stage, thirty-two stored words and the buffer-full byte.
      check("fill", acc, 34);
      repeat (10) @(posedge clk);
      chk_st(4'b1110, 1'b0);
      pulse(2, 8'h00);
      xfer(8'($urandom), 1'b0);
      chk_st(4'b1110, 1'b0);
      rx_ready <= 1'b1;
      repeat (60) @(posedge clk);
      chk_st(4'b0110, 1'b0);
      pulse(2, 8'h00);
      xfer(8'($urandom), 1'b0);
      chk_st(4'b0110, 1'b0);
      master.stop_cond();
      pulse(1, 8'h00);
      pulse(2, 8'h00);
      chk_st(4'h0, 1'b0);
      master.start_cond();
      xfer({a7, 1'b0}, 1'b1);
      xfer(8'($urandom), 1'b1);
      master.stop_cond();
      @(posedge clk);
      port_enable <= 1'b0;
      master.start_cond();
      xfer({a7, 1'b0}, 1'b0);
      master.stop_cond();
      @(posedge clk);
      port_enable <= 1'b1;
      ten_bit_mode <= 1'b1;
      a10 = 10'($urandom);
      // first byte sent as a write
      hi = {5'h1e, a10[9:8], 1'b0};
      pulse(2, 8'h00);
      pulse(0, hi);
      master.start_cond();
      xfer(hi, 1'b1);
      chk_st(4'b0011, 1'b1);
      pulse(0, a10[7:0]);
      pulse(2, 8'h00);
      chk_st(4'h0, 1'b0);
      xfer(a10[7:0], 1'b1);
      chk_st(4'b0011, 1'b1);
      pulse(0, hi);
      pulse(2, 8'h00);
      chk_st(4'h0, 1'b0);
      xfer(8'($urandom), 1'b1);
      b = 8'($urandom);
      tx_byte <= b;
      pulse(2, 8'h00);
      master.start_cond();
      xfer(hi | 8'h01, 1'b1);
      chk_st(4'b0010, 1'b0);
      check("irq", {31'h0, irq}, 32'h0);
      master.recv_byte(1'b1, got);
      check("tx_byte", {24'h0, got}, {24'h0, b});
      master.stop_cond();
      repeat (50) @(posedge clk);
      check("queue", exp_q.size(), 32'h0);
      check("stuck", {31'h0, stuck}, 32'h0);
      conclude();
   end
endmodule : testbench
